// ### link_cfg_pkg.sv
`default_nettype none
package link_cfg_pkg;

  // ----------------------------------------------------------------
  // Device register map (device's own port)
  // ----------------------------------------------------------------
  localparam logic [9:0] PAIR_EN_ADDR   = 10'h209;
  localparam logic [9:0] SH_SEL_ADDR    = 10'h20f;
  localparam logic [9:0] THRESH_ADDR    = 10'h210;
  localparam logic [7:0] PAIR_EN_RST    = 8'h03;
  localparam logic [7:0] SH_SEL_RST     = 8'h00;
  localparam logic [7:0] THRESH_RST     = 8'h03;
  localparam logic [7:0] PAIR_EN_MASK   = 8'h07;
  localparam logic [7:0] SH_SEL_MASK    = 8'h03;
  localparam logic [7:0] THRESH_MASK    = 8'h1f;
  localparam int         FIRST_PAIR_BIT = 0;
  localparam int         SECOND_PAIR_BIT = 1;
  localparam int         ONE_CHAN_BIT   = 2;
  localparam logic [1:0] SH_CODE_CRC    = 2'h0;
  localparam logic [1:0] SH_CODE_FEC    = 2'h2;

  // ----------------------------------------------------------------
  // Controller register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CTL_ADDR_OFS   = 8'h04;
  localparam logic [7:0] CTL_DATA_OFS   = 8'h08;
  localparam logic [7:0] CTL_STAT_OFS   = 8'h0c;
  localparam int         CTRL_LINK_BIT  = 0;
  localparam int         CTRL_CAL_BIT   = 1;
  localparam int         CTRL_FMT_BIT   = 2;
  localparam int         ADDR_WR_BIT    = 16;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_REFUSE_BIT = 1;
  localparam int         STAT_SYNC_BIT  = 2;
  localparam int         STAT_REQ_BIT   = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         LINK_DIV_RST   = 2;

  typedef enum logic [1:0] {
    SYNC_WORD_NONE,
    SYNC_WORD_CRC,
    SYNC_WORD_FEC
  } sync_word_t;

endpackage
`default_nettype wire

// ### cfg_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cfg_link_if;
  logic       req;
  logic       we;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       link_on;
  logic       cal_on;
  logic       fmt_66;
  logic       sync_n;

  modport dev (
    input  req, we, addr, wdata, link_on, cal_on, fmt_66, sync_n,
    output ack, rdata
  );
  modport ctl (
    output req, we, addr, wdata, link_on, cal_on, fmt_66, sync_n,
    input  ack, rdata
  );
endinterface
`default_nettype wire

// ### link_channel_cfg.sv
// Overview of operation
// - One-channel select keeps only channel A running.
// - Software keeps first pair enabled in one-channel mode.
// - Second pair enable drives channels C, D.
// - First pair enable drives channels A, B.
// - Clear calibration and link enable before channel changes.
// - Never clear both pair enables.
// - Pair off halves converters, lanes rounded up.
// - Odd lane count with pair off pads tail.
// - First pair off moves C, D into A, B slots.
// - Software writes zero to reserved upper bits.
// - Header code 0 CRC, code 2 FEC.
// - Header select matters only in 64B/66B.
// - Command fields always sent as zero.
// - Header select changed only with link disabled.
// - Sync request threshold resets to three.
// - Low for threshold plus one samples requests sync.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module link_channel_cfg
  import link_cfg_pkg::*;
#(
  parameter int BASE_LANES = 8,
  parameter int BASE_CONV  = 4,
  parameter int LINK_DIV   = LINK_DIV_RST
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Register port and link status from the controller
  cfg_link_if.dev         lnk,
  // Datapath configuration
  output logic [3:0]      chan_on_q,
  output logic [7:0]      lane_count_q,
  output logic [7:0]      conv_count_q,
  output logic            tail_pad_q,
  output logic            pair_swap_q,
  output logic            config_bad_q,
  output sync_word_t      sync_word_q,
  output logic [7:0]      cmd_field_q,
  // Sync request
  output logic            sync_request_q,
  output logic            sync_level_q
);

  initial begin
    if (BASE_LANES < 1 || BASE_LANES > 255 || BASE_CONV < 2 || BASE_CONV > 255 ||
        BASE_CONV % 2 != 0 || LINK_DIV < 1 || LINK_DIV > 255) begin
      $error("link_channel_cfg: unsupported parameter values");
    end
  end

  function automatic logic [7:0] ceil_half(input int n);
    ceil_half = 8'((n + 1) / 2);
  endfunction

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  logic       ack_q;
  logic [7:0] rdata_q;
  logic [2:0] ch_q;
  logic [1:0] sh_q;
  logic [4:0] thresh_q;

  wire       take    = lnk.req & ~ack_q;
  wire       hit_ch  = lnk.addr == PAIR_EN_ADDR;
  wire       hit_sh  = lnk.addr == SH_SEL_ADDR;
  wire       hit_th  = lnk.addr == THRESH_ADDR;
  wire       wr      = take & lnk.we;
  wire [7:0] rdata_d = hit_ch ? {5'h00, ch_q} :
                       hit_sh ? {6'h00, sh_q} :
                       hit_th ? {3'h0, thresh_q} : 8'h00;

  assign lnk.ack   = ack_q;
  assign lnk.rdata = rdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q    <= 1'b0;
      rdata_q  <= 8'h00;
      ch_q     <= PAIR_EN_RST[2:0];
      sh_q     <= SH_SEL_RST[1:0];
      thresh_q <= THRESH_RST[4:0];
    end else begin
      ack_q <= take;
      if (take) begin
        rdata_q <= rdata_d;
      end
      // Reserved bits are not stored, so they always read back zero
      if (wr && hit_ch) begin
        ch_q <= lnk.wdata[2:0];
      end
      if (wr && hit_sh) begin
        sh_q <= lnk.wdata[1:0];
      end
      if (wr && hit_th) begin
        thresh_q <= lnk.wdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel and lane configuration
  // ----------------------------------------------------------------
  wire first_on  = ch_q[FIRST_PAIR_BIT];
  wire second_on = ch_q[SECOND_PAIR_BIT];
  wire one_chan  = ch_q[ONE_CHAN_BIT];
  // Both pairs off is undefined; one-channel without the first pair too
  wire bad_d     = (~first_on & ~second_on) | (one_chan & ~first_on);
  wire half      = ~bad_d & (one_chan | (first_on ^ second_on));

  wire [3:0] chan_d = bad_d    ? 4'h0 :
                      one_chan ? 4'h1 :
                      {second_on, second_on, first_on, first_on};

  wire [7:0] lanes_d = half ? ceil_half(BASE_LANES) : 8'(BASE_LANES);
  wire [7:0] conv_d  = half ? 8'(BASE_CONV / 2) : 8'(BASE_CONV);
  wire       tail_d  = half & (BASE_LANES % 2 == 1);
  wire       swap_d  = ~bad_d & ~first_on & second_on;

  // Reserved header codes fall back to CRC rather than an unknown word
  wire sync_word_t sh_sel = (sh_q == SH_CODE_FEC) ? SYNC_WORD_FEC : SYNC_WORD_CRC;
  wire sync_word_t sw_d   = lnk.fmt_66 ? sh_sel : SYNC_WORD_NONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_on_q    <= 4'hf;
      lane_count_q <= 8'h00;
      conv_count_q <= 8'h00;
      tail_pad_q   <= 1'b0;
      pair_swap_q  <= 1'b0;
      config_bad_q <= 1'b0;
      sync_word_q  <= SYNC_WORD_NONE;
      cmd_field_q  <= 8'h00;
    end else begin
      chan_on_q    <= chan_d;
      lane_count_q <= lanes_d;
      conv_count_q <= conv_d;
      tail_pad_q   <= tail_d;
      pair_swap_q  <= swap_d;
      config_bad_q <= bad_d;
      sync_word_q  <= sw_d;
      cmd_field_q  <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Sync request detection on the link rate enable
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic [5:0] low_cnt_q;

  wire tick     = div_q == 8'(LINK_DIV - 1);
  wire is_low   = ~lnk.sync_n;
  // Fires once per low stretch, on sample number threshold plus one
  wire req_hit  = tick & is_low & (low_cnt_q == {1'b0, thresh_q});
  wire cnt_full = &low_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q          <= 8'h00;
      low_cnt_q      <= 6'h00;
      sync_request_q <= 1'b0;
      sync_level_q   <= 1'b1;
    end else begin
      div_q          <= tick ? 8'h00 : div_q + 8'h01;
      sync_request_q <= req_hit;
      if (tick) begin
        sync_level_q <= lnk.sync_n;
        if (!is_low) begin
          low_cnt_q <= 6'h00;
        end else if (!cnt_full) begin
          low_cnt_q <= low_cnt_q + 6'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### link_cfg_controller.sv
`timescale 1ns/10ps
`default_nettype none
module link_cfg_controller
  import link_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Sync pin from the receiver
  input  wire logic        sync_n_pin,
  // Device side
  cfg_link_if.ctl          lnk
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [2:0]  ctrl_q;
  logic [9:0]  dev_addr_q;
  logic        dev_we_q;
  logic [7:0]  data_q;
  logic        busy_q;
  logic        refused_q;
  logic        req_seen_q;
  logic        s1_q;
  logic        s2_q;
  logic        s2_d_q;

  wire acc     = psel & penable & ~pready_q;
  // Writes land on the edge where the master sees pready high
  wire wr      = psel & penable & pready_q & pwrite;
  wire hit_ctl = paddr == CTL_CTRL_OFS;
  wire hit_adr = paddr == CTL_ADDR_OFS;
  wire hit_dat = paddr == CTL_DATA_OFS;
  wire hit_st  = paddr == CTL_STAT_OFS;
  wire mapped  = hit_ctl | hit_adr | hit_dat | hit_st;

  wire [9:0] new_addr = pwdata[9:0];
  wire       new_we   = pwdata[ADDR_WR_BIT];
  wire [7:0] dmask    = (new_addr == PAIR_EN_ADDR) ? PAIR_EN_MASK :
                        (new_addr == SH_SEL_ADDR) ? SH_SEL_MASK :
                        (new_addr == THRESH_ADDR) ? THRESH_MASK : 8'hff;
  wire [7:0] wbyte    = data_q & dmask;
  wire       ch_bad   = (new_addr == PAIR_EN_ADDR) &
                        (ctrl_q[CTRL_LINK_BIT] | ctrl_q[CTRL_CAL_BIT] |
                         (wbyte[1:0] == 2'b00) |
                         (wbyte[ONE_CHAN_BIT] & ~wbyte[FIRST_PAIR_BIT]));
  wire       sh_bad   = (new_addr == SH_SEL_ADDR) & ctrl_q[CTRL_LINK_BIT];
  wire       launch   = wr & hit_adr;
  wire       refuse   = launch & (busy_q | (new_we & (ch_bad | sh_bad)));
  wire       go       = launch & ~refuse;
  // Pulse from the device while this end holds its request
  wire       done     = busy_q & lnk.ack;
  // Event set wins over a software clear in the same cycle
  wire       req_edge = s2_d_q & ~s2_q;

  wire [31:0] rd_d = hit_ctl ? {29'h0, ctrl_q} :
                     hit_adr ? {15'h0, dev_we_q, 6'h00, dev_addr_q} :
                     hit_dat ? {24'h0, data_q} :
                     hit_st  ? {28'h0, req_seen_q, s2_q, refused_q, busy_q} : 32'h0;

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign lnk.req     = busy_q;
  assign lnk.we      = dev_we_q;
  assign lnk.addr    = dev_addr_q;
  assign lnk.wdata   = data_q;
  assign lnk.link_on = ctrl_q[CTRL_LINK_BIT];
  assign lnk.cal_on  = ctrl_q[CTRL_CAL_BIT];
  assign lnk.fmt_66  = ctrl_q[CTRL_FMT_BIT];
  assign lnk.sync_n  = s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q   <= 1'b0;
      prdata_q   <= 32'h0;
      pslverr_q  <= 1'b0;
      ctrl_q     <= 3'h0;
      dev_addr_q <= 10'h000;
      dev_we_q   <= 1'b0;
      data_q     <= 8'h00;
      busy_q     <= 1'b0;
      refused_q  <= 1'b0;
      req_seen_q <= 1'b0;
      s1_q       <= 1'b1;
      s2_q       <= 1'b1;
      s2_d_q     <= 1'b1;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & ~mapped;
      if (acc) begin
        prdata_q <= pwrite ? 32'h0 : rd_d;
      end
      s1_q   <= sync_n_pin;
      s2_q   <= s1_q;
      s2_d_q <= s2_q;
      if (wr && hit_ctl) begin
        ctrl_q <= pwdata[2:0];
      end
      if (wr && hit_dat && !busy_q) begin
        data_q <= pwdata[7:0];
      end
      if (go) begin
        dev_addr_q <= new_addr;
        dev_we_q   <= new_we;
        data_q     <= new_we ? wbyte : data_q;
        busy_q     <= 1'b1;
      end else if (done) begin
        busy_q <= 1'b0;
        if (!dev_we_q) begin
          data_q <= lnk.rdata;
        end
      end
      if (refuse) begin
        refused_q <= 1'b1;
      end else if (go) begin
        refused_q <= 1'b0;
      end
      if (req_edge) begin
        req_seen_q <= 1'b1;
      end else if (wr && hit_st && pwdata[STAT_REQ_BIT]) begin
        req_seen_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### link_cfg_properties.sv
`timescale 1ns/10ps
`default_nettype none
module link_cfg_properties
  import link_cfg_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Device port
  input wire logic       req,
  input wire logic       we,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       link_on,
  input wire logic       cal_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic ch_wr = req && we && addr == PAIR_EN_ADDR;
  wire logic sh_wr = req && we && addr == SH_SEL_ADDR;

  ack_follows_req_a: assert property (req && !ack |=> ack)
    else $error("ack late");
  ack_release_a: assert property (ack |=> !ack && !req)
    else $error("ack or req held");
  ack_cause_a: assert property (ack |-> req && $past(req))
    else $error("ack without request");
  req_hold_a: assert property (req && !ack |=> $stable({we, addr, wdata}))
    else $error("request moved");
  ch_safe_a: assert property (ch_wr |-> !link_on && !cal_on)
    else $error("channel write while running");
  ch_valid_a: assert property (ch_wr |-> wdata[1:0] != 2'h0 && (!wdata[2] || wdata[0]))
    else $error("undefined channel setting written");
  zero_bits_a: assert property (ch_wr |-> wdata[7:3] == 5'h00)
    else $error("reserved channel bits written");
  sh_safe_a: assert property (sh_wr |-> !link_on && wdata[7:2] == 6'h00)
    else $error("header write while link on");
  rd_zero_a: assert property (ack && !we && addr == PAIR_EN_ADDR |-> rdata[7:3] == 5'h00)
    else $error("reserved bits read back");
  cover property (ch_wr);
  cover property (sh_wr);
  cover property (ack && !we);
endmodule
`default_nettype wire

// ### serial_link_channel_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module serial_link_channel_config_tb
  import link_cfg_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sync_n_pin = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, slv, rfs, sync_request_q, sync_level_q, tail_pad_q, pair_swap_q;
  logic config_bad_q;
  logic [3:0] chan_on_q;
  logic [7:0] lane_count_q, conv_count_q, cmd_field_q;
  sync_word_t sync_word_q;
  int fails = 0, n_tests = 0, cyc = 0, pulses = 0;
  cfg_link_if lnk ();

  link_cfg_controller u_link_cfg_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_n_pin(sync_n_pin), .lnk(lnk.ctl));
  // Odd lane count so the tail padding shows
  link_channel_cfg #(.BASE_LANES(5), .BASE_CONV(4), .LINK_DIV(2)) u_link_channel_cfg (
    .pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .chan_on_q(chan_on_q),
    .lane_count_q(lane_count_q), .conv_count_q(conv_count_q), .tail_pad_q(tail_pad_q),
    .pair_swap_q(pair_swap_q), .config_bad_q(config_bad_q), .sync_word_q(sync_word_q),
    .cmd_field_q(cmd_field_q), .sync_request_q(sync_request_q), .sync_level_q(sync_level_q));
  link_cfg_properties u_link_cfg_properties (.pclk(pclk), .presetn(presetn), .req(lnk.req),
    .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata),
    .link_on(lnk.link_on), .cal_on(lnk.cal_on));

  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (sync_request_q === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Leaves the refusal flag in rfs and the data register in rd
  task dev(input logic w, input logic [9:0] a, input logic [7:0] d);
    apb(1, CTL_DATA_OFS, {24'h0, d});
    apb(1, CTL_ADDR_OFS, {15'h0, w, 6'h0, a});
    do apb(0, CTL_STAT_OFS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
    rfs = rd[STAT_REFUSE_BIT];
    apb(0, CTL_DATA_OFS, 32'h0);
  endtask
  task pulse(input int n, input int e);
    pulses = 0;
    @(posedge pclk);
    sync_n_pin <= 0;
    repeat (n) @(posedge pclk);
    sync_n_pin <= 1;
    repeat (20) @(posedge pclk);
    chk(pulses, e);
    chk(sync_level_q, 1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk({chan_on_q, tail_pad_q, pair_swap_q, lane_count_q, conv_count_q}, 22'h3c0504);
    dev(0, PAIR_EN_ADDR, 8'h00); chk(rd[7:0], 8'h03);
    dev(0, SH_SEL_ADDR, 8'h00); chk(rd[7:0], 8'h00);
    dev(0, THRESH_ADDR, 8'h00); chk(rd[7:0], 8'h03);
    apb(0, 8'h40, 32'h0); chk({31'h0, slv}, 32'h1);
    chk(rd, 32'h0);
  endtask
  task t_chan;
    logic [7:0] wv[4] = '{8'h01, 8'h02, 8'hfd, 8'h03};
    logic [7:0] rb[4] = '{8'h01, 8'h02, 8'h05, 8'h03};
    logic [21:0] ex[4] = '{22'h0d0302, 22'h330302, 22'h050302, 22'h3c0504};
    for (int i = 0; i < 4; i++) begin
      dev(1, PAIR_EN_ADDR, wv[i]); chk(rfs, 0);
      chk({chan_on_q, pair_swap_q, tail_pad_q, lane_count_q, conv_count_q}, ex[i]);
      dev(0, PAIR_EN_ADDR, 8'h00); chk(rd[7:0], rb[i]);
    end
    dev(1, PAIR_EN_ADDR, 8'h00); chk(rfs, 1);
    dev(1, PAIR_EN_ADDR, 8'h04); chk(rfs, 1);
    apb(1, CTL_CTRL_OFS, 32'h2); dev(1, PAIR_EN_ADDR, 8'h01); chk(rfs, 1);
    apb(1, CTL_CTRL_OFS, 32'h1); dev(1, PAIR_EN_ADDR, 8'h01); chk(rfs, 1);
    chk({config_bad_q, chan_on_q}, 5'h0f);
  endtask
  task t_hdr;
    chk(sync_word_q, SYNC_WORD_NONE);
    apb(1, CTL_CTRL_OFS, 32'h4);
    for (int i = 0; i < 4; i++) begin
      dev(1, SH_SEL_ADDR, 8'(i));
      chk(sync_word_q, (i == 2) ? SYNC_WORD_FEC : SYNC_WORD_CRC);
    end
    apb(1, CTL_CTRL_OFS, 32'h5);
    dev(1, SH_SEL_ADDR, 8'h02); chk({rfs, sync_word_q}, {1'b1, SYNC_WORD_CRC});
    apb(1, CTL_CTRL_OFS, 32'h0);
    apb(0, CTL_STAT_OFS, 32'h0);
    chk(sync_word_q, SYNC_WORD_NONE);
    chk(cmd_field_q, 8'h00);
  endtask
  task t_sync;
    pulse(5, 0);
    pulse(30, 1);
    dev(1, THRESH_ADDR, 8'h00);
    pulse(3, 1);
  endtask

  task summarize;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    t_reset;
    t_chan;
    t_hdr;
    t_sync;
    summarize;
  end
endmodule
`default_nettype wire
